//--- sris_pkg.sv
// Constants and types of the switch reset and init sequencer
// Contract
// - Straps captured at pin release; reused when pin not asserted
// - Captured three-bit switch mode select decides the operating mode
// - PLL and SerDes reset and lock, then training starts while sequence continues
// - Reset halt strap sets the reset halt status bit during fundamental reset
// - Every link reaches active training within 20ms of reset clearing
// - Within 100ms config requests get retry; others ignored
// - Master SMBus runs 100 KHz when slow strap set, else 400 KHz
// - Slave SMBus released with strap address first, then master SMBus
// - Mode 0x1 loads EEPROM contents into addressed registers
// - EEPROM write of full link retrain bit retrains that port at once
// - EEPROM error aborts load, sets control halt bit, records error details
// - EEPROM done bit set when load ends, completed or failed
// - Halt bit holds logic in reset until cleared through slave SMBus
// - Warm reset request write completes successfully before warm reset starts
// - Fundamental reset turns every general-purpose pin into an input
// - Hot reset on upstream TS1 hot bit, DL_Down or request bit
// - Link-down hot reset disable suppresses only the DL_Down trigger
// - Hot reset sends TS1 hot bit on every linked downstream port
// - Hot reset clears all but PLL, SerDes, SMBus; sticky fields kept
// - Hot reset reloads EEPROM only if mode needs it and skip clear
// - During hot reset held registers read zero and writes are discarded
// - Hot reset request write completes first, then upstream fully retrains
// - Mode 0x0 normal, 0x1 normal with EEPROM, 0x2 to 0x7 reserved
// - Warm reset request bit starts a warm fundamental reset
package sris_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned TRAIN_MS = 20;
  localparam int unsigned TRAIN_CYC = TRAIN_MS * (CLK_HZ / 1000);
  localparam int unsigned MSMB_SLOW_KHZ = 100;
  localparam int unsigned MSMB_FAST_KHZ = 400;
  localparam logic [7:0] MSMB_DIV_SLOW = 8'(CLK_HZ / (MSMB_SLOW_KHZ * 1000));
  localparam logic [7:0] MSMB_DIV_FAST = 8'(CLK_HZ / (MSMB_FAST_KHZ * 1000));
  localparam logic [3:0] HOT_HOLD_CYC = 4'hf;

  localparam int NPORT = 3;
  localparam int NGPIO = 8;

  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_EEPROM = 3'h1;

  localparam logic [6:0] SSMB_ADDR_BASE = 7'h40;

  localparam logic [7:0] OFS_CTL = 8'h00;
  localparam logic [7:0] OFS_STS = 8'h04;
  localparam logic [7:0] OFS_SMBSTS = 8'h08;
  localparam logic [7:0] OFS_PHYLS = 8'h0c;
  localparam logic [7:0] OFS_GPIO = 8'h10;

  localparam int CTL_WARM = 0;
  localparam int CTL_HOT = 1;
  localparam int CTL_HALT = 2;
  localparam int CTL_LDDIS = 3;
  localparam int CTL_EESKIP = 4;

  localparam int STS_MODE = 0;
  localparam int STS_HALT = 3;
  localparam int STS_SLOW = 4;
  localparam int STS_ADDR = 5;
  localparam int STS_MODE_RSVD = 9;
  localparam int STS_TRAIN_LATE = 10;

  localparam int SMBSTS_DONE = 0;
  localparam int SMBSTS_ERR = 1;
  localparam int SMBSTS_CODE = 4;

  localparam logic [2:0] STRAP_MODE_RST = 3'h0;
  localparam logic [7:0] GPIO_OE_RST = 8'h00;

  typedef enum logic [3:0] {
    ST_WARM_RESET_REQUEST_WAIT, ST_SAMPLE, ST_MODE, ST_PLL, ST_TRAIN, ST_SSMB,
    ST_MSMB, ST_EEPROM, ST_HALT, ST_RUN, ST_HOT
  } sris_state_t;
endpackage

//--- sris_sync2.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module sris_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;

  // Resets to zero, so the reset pin reads as asserted until sampled
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

//--- sris_cfg_gate.sv
// Request gate of the stacks: pass, retry or ignore
`timescale 1ns/1ns
module sris_cfg_gate (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Sequencer state
  input wire logic quasi,
  input wire logic run,
  // Incoming request
  input wire logic req_valid,
  input wire logic req_is_cfg,
  // Outcome
  output logic pass_valid,
  output logic retry_cpl
);
  assign pass_valid = req_valid && run;

  // Non-config requests in quasi-reset are dropped silently
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      retry_cpl <= 1'b0;
    end else begin
      retry_cpl <= req_valid && req_is_cfg && quasi;
    end
  end
endmodule

//--- sris_seq.sv
// Reset and initialisation sequencer of the switch
`timescale 1ns/1ns
module sris_seq #(
  parameter int unsigned TRAIN_LIMIT_CYC = sris_pkg::TRAIN_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Reset pin and boot straps
  input wire logic fundamental_reset_n,
  input wire logic [2:0] switch_mode_select,
  input wire logic reset_halt,
  input wire logic master_smbus_slow_select,
  input wire logic [3:0] slave_smbus_addr_straps,
  // PLL and SerDes
  input wire logic pll_locked,
  output logic pll_serdes_rst,
  // Links
  input wire logic [sris_pkg::NPORT-1:0] link_up,
  input wire logic [sris_pkg::NPORT-1:0] link_training_active,
  input wire logic us_ts1_hot_reset,
  input wire logic us_dl_down,
  output logic link_train_en,
  output logic [sris_pkg::NPORT-1:0] port_retrain,
  output logic [sris_pkg::NPORT-1:0] port_hot_reset_tx,
  output logic us_full_retrain,
  // Stacks
  input wire logic req_valid,
  input wire logic req_is_cfg,
  output logic req_pass_valid,
  output logic cfg_retry_cpl,
  output logic stack_quasi_reset,
  output logic core_rst_n,
  // SMBus control
  output logic ssmb_rst_n,
  output logic [6:0] ssmb_addr,
  output logic msmb_rst_n,
  output logic [7:0] msmb_clk_div,
  // EEPROM loader
  output logic ee_load_start,
  input wire logic ee_wr,
  input wire logic [7:0] ee_addr,
  input wire logic [31:0] ee_data,
  input wire logic ee_done,
  input wire logic ee_err,
  input wire logic [3:0] ee_err_code,
  // General-purpose pins
  output logic [sris_pkg::NGPIO-1:0] gpio_oe,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_from_smbus,
  output logic [31:0] reg_rdata,
  output logic reg_wr_cpl
);
  localparam int NPINS = 11;

  sris_pkg::sris_state_t state_r, state_nxt;
  logic [NPINS-1:0] pins_s;
  logic warm_reset_request_n_s, halt_s, slow_s, lock_s;
  logic [2:0] mode_s;
  logic [3:0] addr_s;
  logic pin_seen_r, hot_path_r, hot_sw_r;
  logic [2:0] mode_r;
  logic strap_halt_r, strap_slow_r, sts_halt_r, sts_late_r;
  logic [3:0] strap_addr_r;
  logic ctl_halt_r, ctl_lddis_r, ctl_skip_r;
  logic warm_pend_r, hot_pend_r;
  logic ee_done_r, ee_err_r;
  logic [3:0] ee_code_r;
  logic [sris_pkg::NGPIO-1:0] gpio_oe_r;
  logic [3:0] hot_cnt_r;
  logic [23:0] qr_cnt_r;
  logic ssmb_on_r, msmb_on_r;
  logic fund_clr, hot_clr, seq_live, ee_need, hot_trig;
  logic ee_wr_ok, w_en, w_smb;
  logic [7:0] w_addr;
  logic [31:0] w_data;

  sris_sync2 #(.WIDTH(NPINS)) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d({fundamental_reset_n, switch_mode_select, reset_halt,
        master_smbus_slow_select, slave_smbus_addr_straps, pll_locked}),
    .q(pins_s)
  );
  assign {warm_reset_request_n_s, mode_s, halt_s, slow_s, addr_s, lock_s} = pins_s;

  function automatic logic [31:0] ctl_word(input logic live);
    logic [31:0] w;
    w = 32'h0;
    w[sris_pkg::CTL_HALT] = live & ctl_halt_r;
    w[sris_pkg::CTL_LDDIS] = ctl_lddis_r;
    w[sris_pkg::CTL_EESKIP] = ctl_skip_r;
    return w;
  endfunction

  function automatic logic in_quasi(input sris_pkg::sris_state_t s);
    return s == sris_pkg::ST_TRAIN || s == sris_pkg::ST_SSMB ||
           s == sris_pkg::ST_MSMB || s == sris_pkg::ST_EEPROM ||
           s == sris_pkg::ST_HALT;
  endfunction

  assign fund_clr = state_r == sris_pkg::ST_WARM_RESET_REQUEST_WAIT;
  assign hot_clr = state_r == sris_pkg::ST_HOT;
  assign seq_live = in_quasi(state_r) || state_r == sris_pkg::ST_RUN;
  assign ee_need = mode_r == sris_pkg::MODE_EEPROM &&
                   (!hot_path_r || !ctl_skip_r);
  assign hot_trig = us_ts1_hot_reset || (us_dl_down && !ctl_lddis_r) ||
                    hot_pend_r;

  // EEPROM writes take the register port's place while loading
  assign ee_wr_ok = ee_wr && state_r == sris_pkg::ST_EEPROM;
  assign w_en = ee_wr_ok || (reg_wr && seq_live);
  assign w_addr = ee_wr_ok ? ee_addr : reg_addr;
  assign w_data = ee_wr_ok ? ee_data : reg_wdata;
  assign w_smb = !ee_wr_ok && reg_from_smbus;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      sris_pkg::ST_WARM_RESET_REQUEST_WAIT: state_nxt = sris_pkg::ST_SAMPLE;
      sris_pkg::ST_SAMPLE: state_nxt = sris_pkg::ST_MODE;
      sris_pkg::ST_MODE: state_nxt = sris_pkg::ST_PLL;
      sris_pkg::ST_PLL: begin
        if (lock_s) begin
          state_nxt = sris_pkg::ST_TRAIN;
        end
      end
      sris_pkg::ST_TRAIN: begin
        if (!hot_path_r) begin
          state_nxt = sris_pkg::ST_SSMB;
        end else if (ee_need) begin
          state_nxt = sris_pkg::ST_EEPROM;
        end else begin
          state_nxt = sris_pkg::ST_RUN;
        end
      end
      sris_pkg::ST_SSMB: state_nxt = sris_pkg::ST_MSMB;
      sris_pkg::ST_MSMB: begin
        if (ee_need) begin
          state_nxt = sris_pkg::ST_EEPROM;
        end else if (ctl_halt_r) begin
          state_nxt = sris_pkg::ST_HALT;
        end else begin
          state_nxt = sris_pkg::ST_RUN;
        end
      end
      sris_pkg::ST_EEPROM: begin
        if (ee_err || (ee_done && ctl_halt_r)) begin
          state_nxt = sris_pkg::ST_HALT;
        end else if (ee_done) begin
          state_nxt = sris_pkg::ST_RUN;
        end
      end
      sris_pkg::ST_HALT: begin
        if (!ctl_halt_r) begin
          state_nxt = sris_pkg::ST_RUN;
        end
      end
      sris_pkg::ST_RUN: state_nxt = sris_pkg::ST_RUN;
      sris_pkg::ST_HOT: begin
        if (hot_cnt_r == sris_pkg::HOT_HOLD_CYC) begin
          state_nxt = sris_pkg::ST_TRAIN;
        end
      end
      default: state_nxt = sris_pkg::ST_WARM_RESET_REQUEST_WAIT;
    endcase
    if (warm_pend_r) begin
      state_nxt = sris_pkg::ST_WARM_RESET_REQUEST_WAIT;
    end else if (hot_trig && seq_live) begin
      state_nxt = sris_pkg::ST_HOT;
    end
    if (!warm_reset_request_n_s) begin
      state_nxt = sris_pkg::ST_WARM_RESET_REQUEST_WAIT;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= sris_pkg::ST_WARM_RESET_REQUEST_WAIT;
      hot_path_r <= 1'b0;
      hot_sw_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_nxt == sris_pkg::ST_WARM_RESET_REQUEST_WAIT) begin
        hot_path_r <= 1'b0;
      end else if (state_nxt == sris_pkg::ST_HOT) begin
        hot_path_r <= 1'b1;
      end
      if (state_nxt == sris_pkg::ST_HOT && state_r != sris_pkg::ST_HOT) begin
        hot_sw_r <= hot_pend_r;
      end
    end
  end

  // Straps: a warm reset without the pin keeps the previous capture
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_seen_r <= 1'b1;
      mode_r <= sris_pkg::STRAP_MODE_RST;
      strap_halt_r <= 1'b0;
      strap_slow_r <= 1'b0;
      strap_addr_r <= 4'h0;
    end else if (!warm_reset_request_n_s) begin
      pin_seen_r <= 1'b1;
    end else if (state_r == sris_pkg::ST_SAMPLE) begin
      pin_seen_r <= 1'b0;
      if (pin_seen_r) begin
        mode_r <= mode_s;
        strap_halt_r <= halt_s;
        strap_slow_r <= slow_s;
        strap_addr_r <= addr_s;
      end
    end
  end

  // Request bits act only after the completion has gone out
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_wr_cpl <= 1'b0;
      warm_pend_r <= 1'b0;
      hot_pend_r <= 1'b0;
    end else begin
      reg_wr_cpl <= reg_wr;
      warm_pend_r <= w_en && w_addr == sris_pkg::OFS_CTL &&
                     w_data[sris_pkg::CTL_WARM];
      hot_pend_r <= w_en && w_addr == sris_pkg::OFS_CTL &&
                    w_data[sris_pkg::CTL_HOT];
    end
  end

  // Halt: hardware set wins over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctl_halt_r <= 1'b0;
      sts_halt_r <= 1'b0;
    end else if (fund_clr || hot_clr) begin
      ctl_halt_r <= 1'b0;
      if (fund_clr) begin
        sts_halt_r <= 1'b0;
      end
    end else if (state_r == sris_pkg::ST_TRAIN && !hot_path_r &&
                 strap_halt_r) begin
      ctl_halt_r <= 1'b1;
      sts_halt_r <= 1'b1;
    end else if (state_r == sris_pkg::ST_EEPROM && ee_err) begin
      ctl_halt_r <= 1'b1;
    end else if (w_en && w_smb && w_addr == sris_pkg::OFS_CTL) begin
      ctl_halt_r <= w_data[sris_pkg::CTL_HALT];
    end
  end

  // Disable and skip bits are sticky across hot reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctl_lddis_r <= 1'b0;
      ctl_skip_r <= 1'b0;
    end else if (fund_clr) begin
      ctl_lddis_r <= 1'b0;
      ctl_skip_r <= 1'b0;
    end else if (w_en && w_addr == sris_pkg::OFS_CTL) begin
      ctl_lddis_r <= w_data[sris_pkg::CTL_LDDIS];
      ctl_skip_r <= w_data[sris_pkg::CTL_EESKIP];
    end
  end

  // EEPROM status; done clears by writing one, a new set wins
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ee_done_r <= 1'b0;
      ee_err_r <= 1'b0;
      ee_code_r <= 4'h0;
    end else if (fund_clr || hot_clr) begin
      ee_done_r <= 1'b0;
      ee_err_r <= 1'b0;
      ee_code_r <= 4'h0;
    end else if (state_r == sris_pkg::ST_EEPROM && (ee_done || ee_err)) begin
      ee_done_r <= 1'b1;
      if (ee_err) begin
        ee_err_r <= 1'b1;
        ee_code_r <= ee_err_code;
      end
    end else if (w_en && w_addr == sris_pkg::OFS_SMBSTS) begin
      ee_done_r <= ee_done_r & ~w_data[sris_pkg::SMBSTS_DONE];
      ee_err_r <= ee_err_r & ~w_data[sris_pkg::SMBSTS_ERR];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gpio_oe_r <= sris_pkg::GPIO_OE_RST;
    end else if (fund_clr || hot_clr) begin
      gpio_oe_r <= sris_pkg::GPIO_OE_RST;
    end else if (w_en && w_addr == sris_pkg::OFS_GPIO) begin
      gpio_oe_r <= w_data[sris_pkg::NGPIO-1:0];
    end
  end
  assign gpio_oe = gpio_oe_r;

  // Quasi-reset timer checks training within the limit
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      qr_cnt_r <= 24'h0;
      sts_late_r <= 1'b0;
      hot_cnt_r <= 4'h0;
    end else begin
      hot_cnt_r <= hot_clr ? hot_cnt_r + 4'h1 : 4'h0;
      if (fund_clr || hot_clr) begin
        qr_cnt_r <= 24'h0;
        sts_late_r <= 1'b0;
      end else if (seq_live && qr_cnt_r != 24'(TRAIN_LIMIT_CYC)) begin
        qr_cnt_r <= qr_cnt_r + 24'h1;
      end else if (qr_cnt_r == 24'(TRAIN_LIMIT_CYC) &&
                   !(&link_training_active)) begin
        sts_late_r <= 1'b1;
      end
    end
  end

  // SMBus blocks survive hot reset, not fundamental reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ssmb_on_r <= 1'b0;
      msmb_on_r <= 1'b0;
      msmb_clk_div <= sris_pkg::MSMB_DIV_FAST;
      ssmb_addr <= sris_pkg::SSMB_ADDR_BASE;
    end else if (fund_clr) begin
      ssmb_on_r <= 1'b0;
      msmb_on_r <= 1'b0;
    end else if (state_r == sris_pkg::ST_SSMB) begin
      ssmb_on_r <= 1'b1;
      msmb_clk_div <= strap_slow_r ? sris_pkg::MSMB_DIV_SLOW :
                      sris_pkg::MSMB_DIV_FAST;
      ssmb_addr <= {sris_pkg::SSMB_ADDR_BASE[6], strap_addr_r[3],
                    sris_pkg::SSMB_ADDR_BASE[4], strap_addr_r[2:0],
                    sris_pkg::SSMB_ADDR_BASE[0]};
    end else if (state_r == sris_pkg::ST_MSMB) begin
      msmb_on_r <= 1'b1;
    end
  end
  assign ssmb_rst_n = ssmb_on_r;
  assign msmb_rst_n = msmb_on_r;

  // Per-port pulses: retrain from register writes, hot reset onward
  genvar gi;
  generate
    for (gi = 0; gi < sris_pkg::NPORT; gi++) begin : g_port
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          port_retrain[gi] <= 1'b0;
          port_hot_reset_tx[gi] <= 1'b0;
        end else begin
          port_retrain[gi] <= w_en && w_addr == sris_pkg::OFS_PHYLS &&
                              w_data[gi];
          port_hot_reset_tx[gi] <= gi != 0 && hot_clr &&
                                   link_up[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      us_full_retrain <= 1'b0;
      ee_load_start <= 1'b0;
    end else begin
      us_full_retrain <= hot_clr && state_nxt == sris_pkg::ST_TRAIN &&
                         hot_sw_r;
      ee_load_start <= state_nxt == sris_pkg::ST_EEPROM &&
                       state_r != sris_pkg::ST_EEPROM;
    end
  end

  // PLL held until its step; training runs from lock on, except in hot reset
  assign pll_serdes_rst = state_r == sris_pkg::ST_WARM_RESET_REQUEST_WAIT ||
                          state_r == sris_pkg::ST_SAMPLE ||
                          state_r == sris_pkg::ST_MODE;
  assign link_train_en = in_quasi(state_r) || state_r == sris_pkg::ST_RUN;
  assign stack_quasi_reset = in_quasi(state_r);
  assign core_rst_n = state_r == sris_pkg::ST_RUN;

  sris_cfg_gate u_gate (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .quasi(stack_quasi_reset),
    .run(core_rst_n),
    .req_valid(req_valid),
    .req_is_cfg(req_is_cfg),
    .pass_valid(req_pass_valid),
    .retry_cpl(cfg_retry_cpl)
  );

  // Read data one cycle after the strobe; held fields read zero in hot reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        sris_pkg::OFS_CTL: reg_rdata <= ctl_word(!hot_clr);
        sris_pkg::OFS_STS: begin
          reg_rdata <= 32'h0;
          reg_rdata[sris_pkg::STS_MODE +: 3] <= mode_r;
          reg_rdata[sris_pkg::STS_HALT] <= sts_halt_r;
          reg_rdata[sris_pkg::STS_SLOW] <= strap_slow_r;
          reg_rdata[sris_pkg::STS_ADDR +: 4] <= strap_addr_r;
          reg_rdata[sris_pkg::STS_MODE_RSVD] <=
            mode_r > sris_pkg::MODE_EEPROM;
          reg_rdata[sris_pkg::STS_TRAIN_LATE] <= sts_late_r;
        end
        sris_pkg::OFS_SMBSTS: begin
          reg_rdata <= 32'h0;
          reg_rdata[sris_pkg::SMBSTS_DONE] <= ee_done_r;
          reg_rdata[sris_pkg::SMBSTS_ERR] <= ee_err_r;
          reg_rdata[sris_pkg::SMBSTS_CODE +: 4] <= ee_code_r;
        end
        sris_pkg::OFS_GPIO: reg_rdata <= {24'h0, gpio_oe_r};
        default: reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end
endmodule

//--- sris_seq_props.sv
// Port checker of the reset and init sequencer
`timescale 1ns/1ns
module sris_seq_props (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Pins and links
  input wire logic fundamental_reset_n,
  input wire logic [sris_pkg::NPORT-1:0] link_up,
  input wire logic pll_serdes_rst,
  input wire logic link_train_en,
  input wire logic [sris_pkg::NPORT-1:0] port_hot_reset_tx,
  // Stacks and registers
  input wire logic req_valid,
  input wire logic req_is_cfg,
  input wire logic req_pass_valid,
  input wire logic cfg_retry_cpl,
  input wire logic stack_quasi_reset,
  input wire logic reg_wr,
  input wire logic reg_wr_cpl,
  // SMBus and pins
  input wire logic ssmb_rst_n,
  input wire logic msmb_rst_n,
  input wire logic [sris_pkg::NGPIO-1:0] gpio_oe
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  a_wr_complete: assert property (reg_wr |=> reg_wr_cpl)
    else $error("write not completed next cycle");
  a_cfg_retry: assert property
    (stack_quasi_reset && req_valid && req_is_cfg |=> cfg_retry_cpl)
    else $error("config not retried");
  a_retry_only_cfg: assert property
    (cfg_retry_cpl |-> $past(req_valid && req_is_cfg))
    else $error("retry without a config request");
  a_quasi_no_pass: assert property (stack_quasi_reset |-> !req_pass_valid)
    else $error("passed in quasi reset");
  a_pll_before_train: assert property (link_train_en |-> !pll_serdes_rst)
    else $error("training while PLL held");
  a_gpio_input: assert property
    (!fundamental_reset_n [*5] |=> gpio_oe == '0)
    else $error("pin driven in reset");
  a_hot_linked: assert property (|port_hot_reset_tx |->
    !port_hot_reset_tx[0] && (port_hot_reset_tx & ~link_up) == '0)
    else $error("hot reset sent on wrong port");
  a_slave_first: assert property
    ($rose(msmb_rst_n) |-> ssmb_rst_n && $past(ssmb_rst_n))
    else $error("master before slave");
endmodule

bind sris_seq sris_seq_props u_props (.*);

//--- sris_far_model.sv
// Far-side model: PLL, link trainers and serial EEPROM loader
`timescale 1ns/1ns
module sris_far_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // From the sequencer
  input wire logic pll_serdes_rst,
  input wire logic link_train_en,
  input wire logic ee_load_start,
  // Scenario control
  input wire logic inject_err,
  // Towards the sequencer
  output logic pll_locked,
  output logic [2:0] link_training_active,
  output logic ee_wr,
  output logic [7:0] ee_addr,
  output logic [31:0] ee_data,
  output logic ee_done,
  output logic ee_err,
  output logic [3:0] ee_err_code
);
  logic [2:0] lock_cnt_r;
  logic [2:0] ee_cnt_r;

  assign ee_err_code = 4'h9;
  // Lock comes late so the sequencer must really wait for it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lock_cnt_r <= 3'h0;
      pll_locked <= 1'b0;
    end else if (pll_serdes_rst) begin
      lock_cnt_r <= 3'h0;
      pll_locked <= 1'b0;
    end else if (lock_cnt_r != 3'h7) begin
      lock_cnt_r <= lock_cnt_r + 3'h1;
    end else begin
      pll_locked <= 1'b1;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      link_training_active <= 3'h0;
    end else begin
      link_training_active <= link_train_en ? 3'h7 : 3'h0;
    end
  end
  // Idle address and data toggle so no stale value looks valid
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      {ee_cnt_r, ee_wr, ee_done, ee_err, ee_addr, ee_data} <= '0;
    end else begin
      ee_wr <= ee_cnt_r == 3'h3;
      ee_done <= ee_cnt_r == 3'h5 && !inject_err;
      ee_err <= ee_cnt_r == 3'h5 && inject_err;
      ee_addr <= ee_cnt_r == 3'h3 ? sris_pkg::OFS_PHYLS : ~ee_addr;
      ee_data <= ee_cnt_r == 3'h3 ? 32'h2 : ~ee_data;
      if (ee_load_start) begin
        ee_cnt_r <= 3'h1;
      end else if (ee_cnt_r != 3'h0) begin
        ee_cnt_r <= ee_cnt_r + 3'h1;
      end
    end
  end
endmodule

//--- testbench.sv
// Self-checking bench of the reset and init sequencer
`timescale 1ns/1ns
module testbench;
  typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d;} sris_row_t;
  logic clk_sys, rst_n, fundamental_reset_n, reset_halt, pll_locked;
  logic master_smbus_slow_select, us_ts1_hot_reset, us_dl_down, inject_err;
  logic req_valid, req_is_cfg, reg_wr, reg_rd, reg_from_smbus, ee_err;
  logic pll_serdes_rst, link_train_en, us_full_retrain, req_pass_valid;
  logic cfg_retry_cpl, stack_quasi_reset, core_rst_n, ssmb_rst_n, ee_done;
  logic msmb_rst_n, ee_load_start, ee_wr, reg_wr_cpl, run_ok;
  logic [2:0] switch_mode_select, link_up, link_training_active;
  logic [2:0] port_retrain, port_hot_reset_tx, seen_retrain;
  logic [3:0] slave_smbus_addr_straps, ee_err_code;
  logic [6:0] ssmb_addr;
  logic [7:0] msmb_clk_div, ee_addr, reg_addr, gpio_oe;
  logic [31:0] ee_data, reg_wdata, reg_rdata;
  int error_cnt, cmp_count, i;
  sris_row_t rows [8] = '{'{1, 8'h10, 32'ha5}, '{0, 8'h10, 32'ha5},
    '{1, 8'h10, 32'h0}, '{1, 8'h00, 32'h18}, '{0, 8'h00, 32'h18},
    '{0, 8'h20, 32'h0}, '{0, 8'h0c, 32'h0}, '{0, 8'h04, 32'h170}};

  sris_seq #(.TRAIN_LIMIT_CYC(50)) uut (.clk_sys, .rst_n,
    .fundamental_reset_n, .switch_mode_select, .reset_halt,
    .master_smbus_slow_select, .slave_smbus_addr_straps, .pll_locked,
    .pll_serdes_rst, .link_up, .link_training_active, .us_ts1_hot_reset,
    .us_dl_down, .link_train_en, .port_retrain, .port_hot_reset_tx,
    .us_full_retrain, .req_valid, .req_is_cfg, .req_pass_valid,
    .cfg_retry_cpl, .stack_quasi_reset, .core_rst_n, .ssmb_rst_n,
    .ssmb_addr, .msmb_rst_n, .msmb_clk_div, .ee_load_start, .ee_wr,
    .ee_addr, .ee_data, .ee_done, .ee_err, .ee_err_code, .gpio_oe,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_from_smbus, .reg_rdata,
    .reg_wr_cpl);
  sris_far_model far (.clk_sys, .rst_n, .pll_serdes_rst, .link_train_en,
    .ee_load_start, .inject_err, .pll_locked, .link_training_active, .ee_wr,
    .ee_addr, .ee_data, .ee_done, .ee_err, .ee_err_code);

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Retrain is a one-cycle pulse, so it is latched for a later look
  always @(posedge clk_sys)
    if (port_retrain != 3'h0) seen_retrain <= port_retrain;
  always_comb run_ok = core_rst_n && !stack_quasi_reset;

  task stop_test;
    if (error_cnt == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic smb);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    reg_from_smbus <= smb;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task req(input logic cfg, input logic pass, input logic retry);
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_is_cfg <= cfg;
    #1 chk(32'(req_pass_valid), 32'(pass));
    @(posedge clk_sys);
    req_valid <= 1'b0;
    #1 chk(32'(cfg_retry_cpl), 32'(retry));
  endtask
  task automatic wait_hi(ref logic s);
    for (i = 0; i < 400 && s !== 1'b1; i++) @(posedge clk_sys) #1;
    if (i == 400) begin
      error_cnt++;
      stop_test;
    end
  endtask
  task pulse_pin;
    @(posedge clk_sys);
    fundamental_reset_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    fundamental_reset_n <= 1'b1;
  endtask

  initial begin
    {rst_n, fundamental_reset_n, reset_halt, us_ts1_hot_reset} = '0;
    {us_dl_down, req_valid, req_is_cfg, reg_wr, reg_rd} = '0;
    {reg_from_smbus, inject_err, reg_addr, reg_wdata} = '0;
    {switch_mode_select, master_smbus_slow_select} = 4'h1;
    slave_smbus_addr_straps = 4'hb;
    link_up = 3'h7;
    error_cnt = 0;
    cmp_count = 0;
    repeat (4) @(posedge clk_sys);
    chk(32'(pll_serdes_rst), 32'h1);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    fundamental_reset_n <= 1'b1;
    wait_hi(run_ok);
    chk(32'(msmb_clk_div), 32'(sris_pkg::MSMB_DIV_SLOW));
    chk(32'(ssmb_addr), 32'h66);
    foreach (rows[k]) begin
      if (rows[k].wr) wr(rows[k].a, rows[k].d, 1'b0);
      else rd(rows[k].a, rows[k].d);
    end
    req(1'b0, 1'b1, 1'b0);
    @(posedge clk_sys) us_dl_down <= 1'b1;
    repeat (3) @(posedge clk_sys);
    us_dl_down <= 1'b0;
    #1 chk(32'(core_rst_n), 32'h1);
    @(posedge clk_sys) us_ts1_hot_reset <= 1'b1;
    @(posedge clk_sys) us_ts1_hot_reset <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 chk(32'(port_hot_reset_tx), 32'h6);
    chk(32'(core_rst_n), 32'h0);
    wr(8'h10, 32'hff, 1'b1);
    wait_hi(run_ok);
    rd(8'h00, 32'h18);
    rd(8'h10, 32'h0);
    wr(8'h00, 32'h1a, 1'b0);
    wait_hi(us_full_retrain);
    wait_hi(run_ok);
    wr(8'h10, 32'h3c, 1'b0);
    master_smbus_slow_select <= 1'b0;
    slave_smbus_addr_straps <= 4'h0;
    wr(8'h00, 32'h1, 1'b0);
    wait_hi(pll_serdes_rst);
    wait_hi(run_ok);
    chk(32'(gpio_oe), 32'h0);
    rd(8'h04, 32'h170);
    switch_mode_select <= 3'h1;
    pulse_pin;
    wait_hi(run_ok);
    chk(32'(seen_retrain), 32'h2);
    rd(8'h08, 32'h1);
    rd(8'h04, 32'h1);
    inject_err <= 1'b1;
    pulse_pin;
    wait_hi(ee_err);
    req(1'b1, 1'b0, 1'b1);
    rd(8'h08, 32'h93);
    rd(8'h00, 32'h4);
    wr(8'h00, 32'h0, 1'b0);
    rd(8'h00, 32'h4);
    chk(32'(stack_quasi_reset), 32'h1);
    wr(8'h00, 32'h0, 1'b1);
    wait_hi(run_ok);
    stop_test;
  end
endmodule
